// ==== pors_far_model.sv ====
/*
  far-side model: slow oscillator ticks, pll locks and the fabric reset merge.
  assumes: clk is the 100 MHz fast clock; design outputs are clk-domain levels.
*/
`timescale 1ns/100ps
module pors_far_model #(
  parameter int TICK_DIV = 4,
  parameter int LOCK_DLY = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic slow_osc_en,
  input wire logic fabric_por_n,
  input wire logic subsys_to_fabric_reset_n,
  output logic slow_tick,
  output logic fabric_pll_lock,
  output logic subsys_pll_lock,
  output logic fab_user_reset_n
);
  int div;
  int lk;
  // ticks only while the slow oscillator is enabled; locks follow fabric release
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div <= 0;
      lk <= 0;
      slow_tick <= 1'b0;
      fabric_pll_lock <= 1'b0;
      subsys_pll_lock <= 1'b0;
    end
    else
    begin
      div <= (slow_osc_en && div < TICK_DIV - 1) ? div + 1 : 0;
      slow_tick <= slow_osc_en && div == TICK_DIV - 1;
      lk <= !fabric_por_n ? 0 : (lk < 3 * LOCK_DLY ? lk + 1 : lk);
      fabric_pll_lock <= fabric_por_n && lk >= LOCK_DLY;
      subsys_pll_lock <= fabric_por_n && lk >= 2 * LOCK_DLY;
    end
  end
  // fabric logic is held while either reset is low
  assign fab_user_reset_n = fabric_por_n & subsys_to_fabric_reset_n;
endmodule : pors_far_model

// ==== pors_pkg.sv ====
/*
  types for the power-on reset sequencer.
  assumes: compiled before the design modules.
*/
package pors_pkg;
  typedef enum logic [7:0] {
    PS_HOLD = 8'h01,
    PS_BLOCKS_ON = 8'h02,
    PS_INBUF_ON = 8'h04,
    PS_FAB_RELEASE = 8'h08,
    PS_FPLL_WAIT = 8'h10,
    PS_SPLL_WAIT = 8'h20,
    PS_M2F_RELEASE = 8'h40,
    PS_RUN = 8'h80
  } pors_seq_t;
endpackage : pors_pkg

// ==== pors_regs.svh ====
/*
  timing counts and delay codes for the power-on reset sequencer.
  assumes: included by pors_sequencer only, not by the package; no processes here.
*/
`ifndef PORS_REGS_SVH
`define PORS_REGS_SVH

// slow oscillator rate and delay settings in microseconds
`define PORS_SLOW_OSC_KHZ 1000
`define PORS_DLY_US_0 50
`define PORS_DLY_US_1 1000
`define PORS_DLY_US_2 10000
`define PORS_DLY_US_3 100000
// delay select codes
`define PORS_SEL_50US 2'h0
`define PORS_SEL_1MS 2'h1
`define PORS_SEL_10MS 2'h2
`define PORS_SEL_100MS 2'h3
// sequence step gap in fast clock cycles and synchronizer depth
`define PORS_STEP_GAP 4
`define PORS_SYNC_STAGES 2

`endif

// ==== pors_reset_sync.sv ====
/*
  reset synchronizer: asserts at once, releases after a chain of flops.
  assumes: clk runs while the reset is released.
*/
`timescale 1ns/100ps
module pors_reset_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic sync_n
);
  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;

  // shift ones in behind the reset
  always_comb
  begin
    next_chain = {chain[STAGES-2:0], 1'b1};
  end

  // assert asynchronously, release synchronously
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      chain <= '0;
    else
      chain <= next_chain;
  end

  assign sync_n = chain[STAGES-1];
endmodule : pors_reset_sync

// ==== pors_sequencer.sv ====
/*
  power-on reset sequencer: delay counter on the slow oscillator tick, then
  ordered power-up steps, synchronized resets on the subsystem clock.
  assumes: clk is the 100 MHz fast clock; slow_tick pulses once per slow
  oscillator period; supply_ok, pll locks and inputs are synchronous to clk.
*/
`timescale 1ns/100ps
`include "pors_regs.svh"
module pors_sequencer
  import pors_pkg::*;
#(
  parameter int SLOW_KHZ = `PORS_SLOW_OSC_KHZ,
  parameter int GAP = `PORS_STEP_GAP
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic subsys_clk,
  input wire logic supply_ok,
  input wire logic slow_tick,
  input wire logic [1:0] delay_sel,
  input wire logic device_reset_pin_n,
  input wire logic fabric_pll_lock,
  input wire logic subsys_pll_lock,
  input wire logic sys_reset_req_n,
  input wire logic [3:0] block_reset_req_n,
  input wire logic cold_flag_clear,
  output logic slow_osc_en,
  output logic fast_osc_en,
  output logic blocks_on,
  output logic inbuf_en,
  output logic fabric_por_n,
  output logic subsys_to_fabric_reset_n,
  output logic outbuf_en,
  output logic por_sync_n,
  output logic memory_subsystem_reset_n,
  output logic fabric_reset_n,
  output logic clkctl_reset_n,
  output logic [3:0] block_reset_n,
  output logic cold_reset_seen,
  output logic core_por_seen_n
);
  localparam int CW = 27;
  // terminal counts: delay in us times slow rate, rounded up
  localparam logic [CW-1:0] TC0 = CW'((`PORS_DLY_US_0 * SLOW_KHZ + 999) / 1000);
  localparam logic [CW-1:0] TC1 = CW'((`PORS_DLY_US_1 * SLOW_KHZ + 999) / 1000);
  localparam logic [CW-1:0] TC2 = CW'((`PORS_DLY_US_2 * SLOW_KHZ + 999) / 1000);
  localparam logic [CW-1:0] TC3 = CW'((`PORS_DLY_US_3 * SLOW_KHZ + 999) / 1000);
  localparam logic [3:0] GAPC = 4'(GAP);

  logic core_por_n;
  logic next_core_por_n;
  logic powered;
  logic next_powered;
  logic [CW-1:0] dly_cnt;
  logic [CW-1:0] next_dly_cnt;
  logic [CW-1:0] term;
  logic [1:0] sel_q;
  logic [1:0] next_sel_q;
  pors_seq_t seq;
  pors_seq_t next_seq;
  logic [3:0] gap_cnt;
  logic [3:0] next_gap_cnt;
  logic [6:0] outs;
  logic [6:0] next_outs;
  logic core_n_q;
  logic next_core_n_q;
  logic por_s_n;
  logic mem_s_n;
  logic fab_s_n;
  logic cc_s_n;
  logic sys_comb_n;
  logic mem_q;
  logic fab_q;
  logic cc_q;
  logic por_q;
  logic cold_q;
  logic next_cold_q;
  logic [3:0] blk_q;

  // terminal count from delay setting captured at power-up
  always_comb
  begin
    case (sel_q)
      `PORS_SEL_50US: term = TC0;
      `PORS_SEL_1MS: term = TC1;
      `PORS_SEL_10MS: term = TC2;
      `PORS_SEL_100MS: term = TC3;
      default: term = TC3;
    endcase
  end

  // core power-on reset and delay counter
  always_comb
  begin
    next_powered = powered;
    next_dly_cnt = dly_cnt;
    next_core_por_n = core_por_n;
    next_sel_q = sel_q;
    if (!powered)
    begin
      next_sel_q = delay_sel; // setting tracked until the delay count ends
      // supply at threshold starts the release
      if (supply_ok && slow_tick)
      begin
        next_dly_cnt = dly_cnt + CW'(1); // counts slow ticks only
        if (dly_cnt + CW'(1) >= term)
        begin
          next_powered = 1'b1;
          next_core_por_n = 1'b1; // release at terminal count
        end
      end
    end
    else if (!device_reset_pin_n)
      next_core_por_n = 1'b0; // pin asserts core reset
    else
      next_core_por_n = 1'b1; // pin release skips the delay count
  end

  // power-up state; arst_n models power-on
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      powered <= 1'b0;
      dly_cnt <= '0;
      core_por_n <= 1'b0; // asserted on power-up
      sel_q <= `PORS_SEL_100MS;
    end
    else
    begin
      powered <= next_powered;
      dly_cnt <= next_dly_cnt;
      core_por_n <= next_core_por_n;
      sel_q <= next_sel_q;
    end
  end

  // ordered power-up steps, restarted by any core reset
  always_comb
  begin
    next_seq = seq;
    next_gap_cnt = gap_cnt;
    // outs: slow_en, fast_en, blocks, inbuf, fab_n, m2f_n, outbuf
    next_outs = outs;
    if (!core_por_n)
    begin
      next_seq = PS_HOLD;
      next_gap_cnt = '0;
      next_outs = {!powered, powered, 5'h00};
    end
    else if (gap_cnt != 4'h0)
      next_gap_cnt = gap_cnt - 4'h1;
    else
    begin
      case (seq)
        PS_HOLD:
        begin
          next_outs[6:5] = 2'b01; // slow off, fast on
          next_seq = PS_BLOCKS_ON;
          next_gap_cnt = GAPC;
        end
        PS_BLOCKS_ON:
        begin
          next_outs[4] = 1'b1; // fabric blocks on first
          next_seq = PS_INBUF_ON;
          next_gap_cnt = GAPC;
        end
        PS_INBUF_ON:
        begin
          next_outs[3] = 1'b1; // input buffers before fabric release
          next_seq = PS_FAB_RELEASE;
          next_gap_cnt = GAPC;
        end
        PS_FAB_RELEASE:
        begin
          next_outs[2] = 1'b1; // fabric power-on reset released
          next_seq = PS_FPLL_WAIT;
        end
        PS_FPLL_WAIT:
          if (fabric_pll_lock)
            next_seq = PS_SPLL_WAIT; // fabric lock first
        PS_SPLL_WAIT:
          if (subsys_pll_lock && fabric_pll_lock)
            next_seq = PS_M2F_RELEASE; // then subsystem lock
        PS_M2F_RELEASE:
        begin
          next_outs[1] = sys_comb_n; // m2f release after both locks
          if (sys_comb_n)
          begin
            next_seq = PS_RUN;
            next_gap_cnt = GAPC;
          end
        end
        PS_RUN:
        begin
          next_outs[1] = sys_comb_n; // system reset reasserts m2f
          next_outs[0] = next_outs[1] & outs[0] | next_outs[1] & outs[1]; // last
        end
        default: next_seq = PS_HOLD;
      endcase
    end
  end

  // sequence registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq <= PS_HOLD;
      gap_cnt <= '0;
      outs <= 7'h40;
    end
    else
    begin
      seq <= next_seq;
      gap_cnt <= next_gap_cnt;
      outs <= next_outs;
    end
  end

  // core reset copy registered into the subsystem domain boundary
  always_comb
  begin
    next_core_n_q = core_por_n;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      core_n_q <= 1'b0;
    else
      core_n_q <= next_core_n_q;
  end

  // synchronized copies of the core reset on the subsystem clock
  pors_reset_sync #(.STAGES(`PORS_SYNC_STAGES)) u_por_sync (
    .clk(subsys_clk),
    .arst_n(core_n_q),
    .sync_n(por_s_n)
  );
  // distinct resets for memory subsystem, fabric and clock ctl
  pors_reset_sync #(.STAGES(`PORS_SYNC_STAGES)) u_mem_sync (
    .clk(subsys_clk),
    .arst_n(core_n_q),
    .sync_n(mem_s_n)
  );
  pors_reset_sync #(.STAGES(`PORS_SYNC_STAGES)) u_fab_sync (
    .clk(subsys_clk),
    .arst_n(core_n_q),
    .sync_n(fab_s_n)
  );
  pors_reset_sync #(.STAGES(`PORS_SYNC_STAGES)) u_cc_sync (
    .clk(subsys_clk),
    .arst_n(core_n_q),
    .sync_n(cc_s_n)
  );

  // system request combined with power-on reset
  assign sys_comb_n = sys_reset_req_n & core_por_n;

  // cold-reset flag: set by synchronized reset wins over clear
  always_comb
  begin
    next_cold_q = cold_q;
    if (!por_s_n)
      next_cold_q = 1'b1;
    else if (cold_flag_clear)
      next_cold_q = 1'b0;
  end

  // subsystem-domain output flops; block requests join here
  always_ff @(posedge subsys_clk or negedge core_n_q)
  begin
    if (!core_n_q)
    begin
      por_q <= 1'b0;
      mem_q <= 1'b0;
      fab_q <= 1'b0;
      cc_q <= 1'b0; // clock controller reset asserted
      blk_q <= '0;
      cold_q <= 1'b1;
    end
    else
    begin
      por_q <= por_s_n;
      mem_q <= mem_s_n;
      fab_q <= fab_s_n;
      cc_q <= cc_s_n;
      blk_q <= block_reset_req_n & {4{mem_s_n}};
      cold_q <= next_cold_q;
    end
  end

  // output assignments straight from flops
  assign slow_osc_en = outs[6];
  assign fast_osc_en = outs[5];
  assign blocks_on = outs[4];
  assign inbuf_en = outs[3];
  assign fabric_por_n = outs[2];
  assign subsys_to_fabric_reset_n = outs[1];
  assign outbuf_en = outs[0];
  assign por_sync_n = por_q;
  assign memory_subsystem_reset_n = mem_q;
  assign fabric_reset_n = fab_q;
  assign clkctl_reset_n = cc_q;
  assign block_reset_n = blk_q;
  assign cold_reset_seen = cold_q;
  assign core_por_seen_n = core_n_q;

  // ordering, pin, delay-count, oscillator and reset checks
  chk_inbuf_after_blocks: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(inbuf_en) |-> blocks_on) else $error("input buffers before blocks");
  chk_fab_after_inbuf: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(fabric_por_n) |-> inbuf_en) else $error("fabric release before inbuf");
  chk_m2f_after_locks: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(subsys_to_fabric_reset_n) |-> $past(fabric_pll_lock) && $past(subsys_pll_lock))
    else $error("m2f released before locks");
  chk_outbuf_last: assert property (@(posedge clk) disable iff (!arst_n)
    outbuf_en |-> subsys_to_fabric_reset_n && fabric_por_n)
    else $error("output buffers enabled early");
  chk_pin_asserts: assert property (@(posedge clk) disable iff (!arst_n)
    powered && !device_reset_pin_n |=> !core_por_n) else $error("pin ignored");
  chk_pin_no_recount: assert property (@(posedge clk) disable iff (!arst_n)
    powered |=> powered && $stable(dly_cnt)) else $error("delay recount");
  chk_release_at_term: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(core_por_n) && !$past(powered) |-> $past(dly_cnt) + CW'(1) >= $past(term))
    else $error("early core release");
  chk_osc_swap: assert property (@(posedge clk) disable iff (!arst_n)
    blocks_on |-> !slow_osc_en && fast_osc_en) else $error("oscillators not swapped");
  chk_cc_reset: assert property (@(posedge subsys_clk) disable iff (!arst_n)
    !core_n_q |-> !clkctl_reset_n) else $error("clock ctl reset missing");
endmodule : pors_sequencer

// ==== pors_sequencer_tb.sv ====
/*
  self-checking bench for the power-on reset sequencer.
  assumes: SLOW_KHZ=100 shortens delays to 5/100/1000/10000 ticks, tick every 4 clks.
*/
`timescale 1ns/100ps
module pors_sequencer_tb;
  import pors_pkg::*;
  localparam int KHZ = 100;
  localparam int LIMIT = 70000;
  logic clk = 0, subsys_clk = 0, arst_n = 0, supply_ok = 0;
  logic device_reset_pin_n = 1, sys_reset_req_n = 1, cold_flag_clear = 0;
  logic [1:0] delay_sel = 2'h0;
  logic [3:0] block_reset_req_n = 4'hF;
  logic slow_tick, fabric_pll_lock, subsys_pll_lock, fab_user_reset_n;
  logic slow_osc_en, fast_osc_en, blocks_on, inbuf_en, fabric_por_n;
  logic subsys_to_fabric_reset_n, outbuf_en, por_sync_n, memory_subsystem_reset_n;
  logic fabric_reset_n, clkctl_reset_n, cold_reset_seen, core_por_seen_n;
  logic [3:0] block_reset_n;
  logic [7:0] steps;
  int t_rise[8];
  int cyc = 0;
  int failures = 0;
  int num_checks = 0;
  int dly_us[4] = '{50, 1000, 10000, 100000};

  pors_sequencer #(.SLOW_KHZ(KHZ), .GAP(4)) i_dut (.clk, .arst_n, .subsys_clk,
    .supply_ok, .slow_tick, .delay_sel, .device_reset_pin_n, .fabric_pll_lock,
    .subsys_pll_lock, .sys_reset_req_n, .block_reset_req_n, .cold_flag_clear,
    .slow_osc_en, .fast_osc_en, .blocks_on, .inbuf_en, .fabric_por_n,
    .subsys_to_fabric_reset_n, .outbuf_en, .por_sync_n, .memory_subsystem_reset_n,
    .fabric_reset_n, .clkctl_reset_n, .block_reset_n, .cold_reset_seen,
    .core_por_seen_n);
  pors_far_model i_far (.clk, .arst_n, .slow_osc_en, .fabric_por_n,
    .subsys_to_fabric_reset_n, .slow_tick, .fabric_pll_lock, .subsys_pll_lock,
    .fab_user_reset_n);

  // clocks: fast clock 10 ns, subsystem clock unrelated 14 ns
  always #5 clk = ~clk;
  always #7 subsys_clk = ~subsys_clk;

  // power-up steps in their documented order
  assign steps = {outbuf_en, subsys_to_fabric_reset_n, subsys_pll_lock,
    fabric_pll_lock, fabric_por_n, inbuf_en, blocks_on, fast_osc_en};

  // first-rise cycle of each step, and the hang limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 8; i++)
      t_rise[i] <= !arst_n ? 0 : (t_rise[i] == 0 && steps[i] ? cyc : t_rise[i]);
    if (cyc == LIMIT)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wait_for(ref logic sig, input int bound);
    for (int n = 0; n < bound && sig !== 1'b1; n++)
      @(posedge clk);
  endtask : wait_for

  task automatic powerup(input logic [1:0] sel);
    int ticks;
    arst_n <= 0;
    supply_ok <= 0;
    delay_sel <= sel;
    repeat (3) @(posedge clk);
    check({slow_osc_en, fast_osc_en, blocks_on, outbuf_en, core_por_seen_n,
      clkctl_reset_n, cold_reset_seen}, 32'h41, "reset values");
    arst_n <= 1;
    repeat (40) @(posedge clk);
    check(core_por_seen_n, 1'b0, "held without supply");
    supply_ok <= 1;
    ticks = 0;
    for (int n = 0; n < 45000 && core_por_seen_n !== 1'b1; n++)
    begin
      @(posedge clk);
      ticks += (slow_tick === 1'b1);
    end
    check(ticks, dly_us[sel] * KHZ / 1000, "delay ticks");
    @(posedge clk);
    check({slow_osc_en, fast_osc_en}, 32'h1, "oscillator swap");
    wait_for(outbuf_en, 500);
    // let the first-rise record of the last step settle before reading it
    @(posedge clk);
    for (int i = 0; i < 7; i++)
      check(32'(t_rise[i] < t_rise[i + 1]), 32'h1, "step order");
    repeat (6) @(posedge subsys_clk);
    check({por_sync_n, memory_subsystem_reset_n, fabric_reset_n, clkctl_reset_n,
      cold_reset_seen, fab_user_reset_n}, 32'h3F, "released resets");
    $display("test powerup sel=%0d done", sel);
  endtask : powerup

  task automatic block_test();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge subsys_clk);
      block_reset_req_n <= ~(4'h1 << i);
      repeat (4) @(posedge subsys_clk);
      check(block_reset_n, 4'(~(4'h1 << i)), "block reset");
      block_reset_req_n <= 4'hF;
      repeat (4) @(posedge subsys_clk);
      check(block_reset_n, 4'hF, "block release");
    end
    $display("test block resets done");
  endtask : block_test

  task automatic sysreset_test();
    @(posedge clk);
    sys_reset_req_n <= 0;
    repeat (4) @(posedge clk);
    check({fabric_por_n, subsys_to_fabric_reset_n, outbuf_en}, 32'h4, "sys reset");
    check(fab_user_reset_n, 1'b0, "fabric held");
    sys_reset_req_n <= 1;
    wait_for(outbuf_en, 100);
    check(outbuf_en, 1'b1, "sys reset recovery");
    $display("test system reset done");
  endtask : sysreset_test

  task automatic pin_test();
    @(posedge subsys_clk);
    cold_flag_clear <= 1;
    @(posedge subsys_clk);
    cold_flag_clear <= 0;
    repeat (3) @(posedge subsys_clk);
    check(cold_reset_seen, 1'b0, "cold flag cleared");
    @(posedge clk);
    device_reset_pin_n <= 0;
    repeat (4) @(posedge subsys_clk);
    check({core_por_seen_n, outbuf_en, fab_user_reset_n}, 32'h0, "pin reset");
    check({por_sync_n, memory_subsystem_reset_n, fabric_reset_n, clkctl_reset_n,
      cold_reset_seen}, 32'h1, "cold reset outputs");
    @(posedge clk);
    device_reset_pin_n <= 1;
    wait_for(outbuf_en, 300);
    check(outbuf_en, 1'b1, "no recount after pin");
    $display("test reset pin done");
  endtask : pin_test

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial
  begin
    powerup(2'h0);
    block_test();
    sysreset_test();
    powerup(2'h1);
    powerup(2'h3);
    powerup(2'h2);
    pin_test();
    tally_and_finish();
  end
endmodule : pors_sequencer_tb
